/* File: design/sfw_flash_ctrl.sv */
// Command logic of a serial flash: latch, identification, status, protection.
// Assumes SPI mode 0 or 3, and chip select high for at least four clk periods.
`timescale 1ns/10ps

// Notes on behaviour
// RL1: A clean set-latch frame sets the write latch.
// RL2: Master sets the latch before every program, erase or status write.
// RL3: Latch commands are one opcode byte framed by chip select.
// RL4: A clean clear-latch frame clears the write latch.
// RL5: Latch clears at reset, clear command, and end of each write cycle.
// RL6: Identify sends maker, two device bytes, length 10h, sixteen custom bytes.
// RL7: Device bytes are fixed memory type then capacity.
// RL8: Custom bytes are read-only and read as 00h.
// RL9: Identify during a busy cycle is not decoded and harms nothing.
// RL10: Master avoids identify during deep power-down.
// RL11: Identify output shifts out on falling clock edges, MSB first.
// RL12: Chip select high ends output; device idles until reselected.
// RL13: Status read is accepted at any time, repeatedly.
// RL14: Master polls the busy bit during write cycles.
// RL15: Busy bit is one during a write cycle, else zero.
// RL16: Latch bit shows the latch; writes are refused while it is zero.
// RL17: Protect bits change only by status write, never in hardware lock.
// RL18: Program and sector erase into a protected area are refused.
// RL19: Bulk erase runs only when all protect bits are zero.
// RL20: Lock bit with write-protect pin low freezes the status byte.
// RL21: Write-type frames must end on a byte boundary or are dropped.
// RL22: Data in is sampled on rising clock edges from select, MSB first.
// RL23: Status readout repeats the latest status byte every eight clocks.
// RL24: A partial byte at deselect is dropped; decoder returns idle.
module sfw_flash_ctrl #(
  parameter int T_WSTATUS_NS = 2000,
  parameter int T_PROGRAM_NS = 4000,
  parameter int T_SECTOR_NS  = 8000,
  parameter int T_BULK_NS    = 16000
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  input  wire logic                wp_n,
  output logic                     miso,
  output logic                     miso_oe,
  output sfw_pkg::sfw_status_type  status,
  output sfw_pkg::sfw_array_op_type array_op
);
  import sfw_pkg::*;

  localparam logic [23:0] CYC_WSTATUS = 24'(ns_to_cycles(T_WSTATUS_NS));
  localparam logic [23:0] CYC_PROGRAM = 24'(ns_to_cycles(T_PROGRAM_NS));
  localparam logic [23:0] CYC_SECTOR  = 24'(ns_to_cycles(T_SECTOR_NS));
  localparam logic [23:0] CYC_BULK    = 24'(ns_to_cycles(T_BULK_NS));

  // Link domain state.
  logic           fresh_q;
  logic [2:0]     bitcnt_q;
  logic [2:0]     bytes_q;
  logic [7:0]     shift_q;
  logic [7:0]     opcode_q;
  logic [7:0]     arg_q;
  logic           frame_tog_q;
  sfw_phase_type  phase_q;
  sfw_status_type status_lk;
  logic [2:0]     cnt_now;
  logic [2:0]     bytes_now;
  logic [7:0]     rx_byte;
  logic           byte_done;
  logic           tx_clear;
  logic [2:0]     tx_bit_q;
  logic [4:0]     tx_idx_q;
  logic [7:0]     tx_shift_q;
  logic [7:0]     tx_next;
  logic           tx_active;
  logic           miso_q;
  logic           miso_oe_q;

  // System domain state.
  logic [2:0]     sync_s;
  logic           cs_s;
  logic           wp_s;
  logic           tog_s;
  logic           tog_seen_q;
  logic           cs_prev_q;
  logic           frame_end;
  logic           aligned;
  logic           hw_lock;
  logic           in_prot;
  logic           go_wstatus;
  logic           go_program;
  logic           go_sector;
  logic           go_bulk;
  logic           go_any;
  logic           busy_q;
  logic [23:0]    busy_cnt_q;
  logic           latch_q;
  logic [2:0]     prot_q;
  logic           lock_q;
  sfw_array_op_type op_q;
  sfw_status_type status_w;

  // A frame starts fresh on its first rising edge; select high re-arms it.
  always_ff @(posedge sclk or posedge tx_clear) begin
    if (tx_clear) begin
      fresh_q <= 1'b1; // see RL24
    end else begin
      fresh_q <= 1'b0;
    end
  end

  assign cnt_now   = fresh_q ? BIT_FIRST : bitcnt_q;
  assign bytes_now = fresh_q ? '0 : bytes_q;
  assign rx_byte   = {shift_q[6:0], mosi};
  assign byte_done = (cnt_now == BIT_LAST);

  // Data is shifted in on rising edges, most significant bit first.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      bitcnt_q    <= BIT_FIRST;
      bytes_q     <= '0;
      shift_q     <= '0;
      frame_tog_q <= 1'b0;
    end else begin
      shift_q  <= rx_byte; // see RL22
      bitcnt_q <= cnt_now + 3'h1; // see RL21
      if (fresh_q) begin
        frame_tog_q <= ~frame_tog_q;
      end
      if (byte_done && bytes_now != BYTES_MAX) begin
        bytes_q <= bytes_now + 3'h1;
      end else begin
        bytes_q <= bytes_now;
      end
    end
  end

  // Opcode and first argument byte are kept for decode after deselect.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      opcode_q <= '0;
      arg_q    <= '0;
    end else if (byte_done) begin
      if (bytes_now == '0) begin
        opcode_q <= rx_byte;
      end
      if (bytes_now == BYTES_ONE) begin
        arg_q <= rx_byte;
      end
    end
  end

  // Read commands pick their output phase as the opcode completes.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_CMD;
    end else if (fresh_q) begin
      phase_q <= PH_CMD; // see RL12
    end else if (byte_done && bytes_now == '0) begin
      if (rx_byte == OP_STATUS) begin
        phase_q <= PH_STATUS; // see RL13
      end else if (rx_byte == OP_IDENT && !status_lk.busy) begin
        phase_q <= PH_IDENT; // see RL9
      end else begin
        phase_q <= PH_QUIET;
      end
    end
  end

  // The status byte reaches the link by handshake, never bit by bit.
  sfw_word_xfer u_xfer (
    .src_clk    (clk),
    .src_resetn (resetn),
    .src_word   (status_w),
    .dst_clk    (sclk),
    .dst_resetn (resetn),
    .dst_word   (status_lk)
  );

  // Identification sequence; custom bytes are constants, so writes cannot reach them.
  function automatic logic [7:0] ident_byte(input logic [4:0] idx);
    if (idx == IDX_MAKER) begin
      return ID_MAKER;
    end else if (idx == IDX_TYPE) begin
      return ID_TYPE;
    end else if (idx == IDX_SIZE) begin
      return ID_SIZE;
    end else if (idx == IDX_LENGTH) begin
      return ID_LENGTH;
    end else if (idx < IDX_END) begin
      return ID_CUSTOM; // see RL8
    end else begin
      return FILL_BYTE;
    end
  endfunction

  assign tx_next   = (phase_q == PH_STATUS) ? status_lk : ident_byte(tx_idx_q); // see RL6
  assign tx_active = !fresh_q && (phase_q == PH_IDENT || phase_q == PH_STATUS);
  assign tx_clear  = cs_n | ~resetn;

  // Output shifts on falling edges; each new byte reloads, so status repeats.
  always_ff @(negedge sclk or posedge tx_clear) begin
    if (tx_clear) begin
      tx_bit_q   <= BIT_FIRST; // see RL12
      tx_idx_q   <= IDX_MAKER;
      tx_shift_q <= '0;
      miso_q     <= 1'b0;
      miso_oe_q  <= 1'b0;
    end else if (tx_active) begin
      miso_oe_q <= 1'b1;
      if (tx_bit_q == BIT_FIRST) begin
        miso_q     <= tx_next[7]; // see RL11
        tx_shift_q <= {tx_next[6:0], 1'b0}; // see RL23
        tx_bit_q   <= BIT_LAST;
        if (tx_idx_q != IDX_END) begin
          tx_idx_q <= tx_idx_q + 5'h01; // see RL7
        end
      end else begin
        miso_q     <= tx_shift_q[7];
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        tx_bit_q   <= tx_bit_q - 3'h1;
      end
    end
  end

  assign miso    = miso_q;
  assign miso_oe = miso_oe_q;

  // Select, write-protect pin and frame toggle enter the system clock.
  sfw_sync #(.W(3)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({cs_n, wp_n, frame_tog_q}),
    .q      (sync_s)
  );
  assign cs_s  = sync_s[2];
  assign wp_s  = sync_s[1];
  assign tog_s = sync_s[0];

  // A frame ends once select is high and a new frame toggle was seen.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_prev_q  <= 1'b1;
      tog_seen_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      if (frame_end) begin
        tog_seen_q <= tog_s;
      end
    end
  end

  // Link words are read only here, while the stopped link holds them still.
  assign frame_end  = cs_s && !cs_prev_q && (tog_s != tog_seen_q);
  assign aligned    = (bitcnt_q == BIT_FIRST); // see RL21
  assign hw_lock    = lock_q && !wp_s; // see RL20
  assign in_prot    = (prot_q != PROT_NONE) &&
                      ({1'b0, arg_q[6:0]} >= SECTOR_TOTAL - (SECTOR_ONE << prot_q)); // see RL18
  assign go_wstatus = frame_end && !busy_q && aligned && latch_q && !hw_lock &&
                      opcode_q == OP_WSTATUS && bytes_q >= BYTES_WSTAT; // see RL16
  assign go_program = frame_end && !busy_q && aligned && latch_q && !in_prot &&
                      opcode_q == OP_PROGRAM && bytes_q >= BYTES_PROG; // see RL2
  assign go_sector  = frame_end && !busy_q && aligned && latch_q && !in_prot &&
                      opcode_q == OP_SECTOR && bytes_q == BYTES_SECT;
  assign go_bulk    = frame_end && !busy_q && aligned && latch_q &&
                      prot_q == PROT_NONE && // see RL19
                      opcode_q == OP_BULK && bytes_q == BYTES_ONE;
  assign go_any     = go_wstatus | go_program | go_sector | go_bulk;

  // Self-timed write cycle; its length depends on the command.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (go_any) begin
      busy_q <= 1'b1; // see RL15
      if (go_wstatus) begin
        busy_cnt_q <= CYC_WSTATUS;
      end else if (go_program) begin
        busy_cnt_q <= CYC_PROGRAM;
      end else if (go_sector) begin
        busy_cnt_q <= CYC_SECTOR;
      end else begin
        busy_cnt_q <= CYC_BULK;
      end
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - BUSY_LAST;
      if (busy_cnt_q == BUSY_LAST) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Write latch; commands arriving during a cycle are ignored.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0; // see RL5
    end else if (busy_q && busy_cnt_q == BUSY_LAST) begin
      latch_q <= 1'b0;
    end else if (frame_end && !busy_q && aligned && bytes_q == BYTES_ONE) begin
      if (opcode_q == OP_SET_LATCH) begin
        latch_q <= 1'b1; // see RL1
      end else if (opcode_q == OP_CLR_LATCH) begin
        latch_q <= 1'b0; // see RL4
      end
    end
  end

  // Protect and lock bits change only through an accepted status write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_q <= PROT_NONE;
      lock_q <= 1'b0;
    end else if (go_wstatus) begin
      prot_q <= arg_q[4:2]; // see RL17
      lock_q <= arg_q[7];
    end
  end

  // One-cycle start notice towards the memory array.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= '0;
    end else begin
      op_q.valid   <= go_any;
      op_q.addr_hi <= arg_q;
      if (go_wstatus) begin
        op_q.kind <= KIND_WSTATUS;
      end else if (go_program) begin
        op_q.kind <= KIND_PROGRAM;
      end else if (go_sector) begin
        op_q.kind <= KIND_SECTOR;
      end else begin
        op_q.kind <= KIND_BULK;
      end
    end
  end

  assign status_w = '{lock: lock_q, rsvd: 2'h0, prot: prot_q, latch: latch_q, busy: busy_q};
  assign status   = status_w;
  assign array_op = op_q;

  // Checks in the system clock domain.
  sequence s_latch_frame(logic [7:0] op);
    frame_end && !busy_q && aligned && bytes_q == BYTES_ONE && opcode_q == op;
  endsequence

  sequence s_locked_write;
    frame_end && opcode_q == OP_WSTATUS && lock_q && !wp_s;
  endsequence

  chk_latch_set: assert property (@(posedge clk) disable iff (!resetn) // see RL1
    s_latch_frame(OP_SET_LATCH) |=> latch_q) else $error("latch not set");
  chk_latch_clear: assert property (@(posedge clk) disable iff (!resetn) // see RL4
    s_latch_frame(OP_CLR_LATCH) |=> !latch_q) else $error("latch not cleared");
  chk_cycle_end: assert property (@(posedge clk) disable iff (!resetn) // see RL5
    $fell(busy_q) |-> !latch_q && !$past(go_any)) else $error("latch after cycle");
  chk_busy_len: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    go_wstatus |=> busy_q && status.busy && busy_cnt_q == CYC_WSTATUS)
    else $error("busy cycle length wrong");
  chk_no_latch: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    frame_end && !busy_q && !latch_q |=> !busy_q) else $error("write without latch");
  chk_sector_prot: assert property (@(posedge clk) disable iff (!resetn) // see RL18
    frame_end && in_prot && opcode_q == OP_SECTOR |=> !op_q.valid)
    else $error("protected sector erased");
  chk_bulk_prot: assert property (@(posedge clk) disable iff (!resetn) // see RL19
    frame_end && opcode_q == OP_BULK && prot_q != PROT_NONE |=> !busy_q)
    else $error("bulk erase while protected");
  chk_hw_lock: assert property (@(posedge clk) disable iff (!resetn) // see RL20
    s_locked_write |=> $stable(prot_q) && $stable(lock_q) && !op_q.valid)
    else $error("status changed under lock");
  chk_ragged_end: assert property (@(posedge clk) disable iff (!resetn) // see RL21
    frame_end && !aligned |=> $stable(latch_q) && !op_q.valid)
    else $error("ragged frame executed");

  // Check in the link domain: output only while a read phase is live.
  chk_out_phase: assert property (@(negedge sclk) disable iff (!resetn || cs_n) // see RL12
    miso_oe_q |-> phase_q == PH_IDENT || phase_q == PH_STATUS)
    else $error("output outside read phase");

endmodule

/* File: design/sfw_pkg.sv */
// Constants, types and opcodes shared by the serial flash command block.
// Assumes a 200 MHz system clock and an SPI link clock that runs only in frames.
package sfw_pkg;

  // One-byte command codes.
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_IDENT     = 8'h9F;
  localparam logic [7:0] OP_STATUS    = 8'h05;
  localparam logic [7:0] OP_WSTATUS   = 8'h01;
  localparam logic [7:0] OP_PROGRAM   = 8'h02;
  localparam logic [7:0] OP_SECTOR    = 8'hD8;
  localparam logic [7:0] OP_BULK      = 8'hC7;

  // Identification bytes; the three code values are arbitrary.
  localparam logic [7:0] ID_MAKER   = 8'hA5;
  localparam logic [7:0] ID_TYPE    = 8'h5A;
  localparam logic [7:0] ID_SIZE    = 8'h3C;
  localparam logic [7:0] ID_LENGTH  = 8'h10;
  localparam logic [7:0] ID_CUSTOM  = 8'h00;
  localparam logic [7:0] FILL_BYTE  = 8'h00;
  localparam logic [4:0] IDX_MAKER  = 5'h00;
  localparam logic [4:0] IDX_TYPE   = 5'h01;
  localparam logic [4:0] IDX_SIZE   = 5'h02;
  localparam logic [4:0] IDX_LENGTH = 5'h03;
  localparam logic [4:0] IDX_END    = 5'h14;

  // Frame length figures in whole bytes, and bit positions within a byte.
  localparam logic [2:0] BYTES_ONE   = 3'h1;
  localparam logic [2:0] BYTES_WSTAT = 3'h2;
  localparam logic [2:0] BYTES_SECT  = 3'h4;
  localparam logic [2:0] BYTES_PROG  = 3'h5;
  localparam logic [2:0] BYTES_MAX   = 3'h7;
  localparam logic [2:0] BIT_FIRST   = 3'h0;
  localparam logic [2:0] BIT_LAST    = 3'h7;

  // Protection geometry: sectors counted on the top address byte.
  localparam logic [7:0] SECTOR_TOTAL = 8'h80;
  localparam logic [7:0] SECTOR_ONE   = 8'h01;
  localparam logic [2:0] PROT_NONE    = 3'h0;

  // Timing: clock rate and busy counter width.
  localparam int          CLK_MHZ    = 200;
  localparam int          NS_PER_US  = 1000;
  localparam int          BUSY_W     = 24;
  localparam logic [23:0] BUSY_LAST  = 24'h00_0001;

  // Status byte layout; the reserved pair always reads as zero.
  typedef struct packed {
    logic       lock;
    logic [1:0] rsvd;
    logic [2:0] prot;
    logic       latch;
    logic       busy;
  } sfw_status_type;

  typedef enum logic [1:0] {
    KIND_WSTATUS,
    KIND_PROGRAM,
    KIND_SECTOR,
    KIND_BULK
  } sfw_kind_type;

  // Start notice for the self-timed cycle, one cycle wide.
  typedef struct packed {
    logic         valid;
    sfw_kind_type kind;
    logic [7:0]   addr_hi;
  } sfw_array_op_type;

  typedef enum {PH_CMD, PH_IDENT, PH_STATUS, PH_QUIET} sfw_phase_type;

  // Least time rounds up to whole clock cycles.
  function automatic int ns_to_cycles(input int ns);
    return (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  endfunction

endpackage

/* File: design/sfw_sync.sv */
// Two-flop level synchroniser, one pair of flops per bit.
// Assumes each input bit is a level that stays put for several clocks.
`timescale 1ns/10ps
module sfw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // The first stage feeds nothing but the second stage.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= d[i];
        sync_q <= meta_q;
      end
    end
    assign q[i] = sync_q;
  end

endmodule

/* File: design/sfw_word_xfer.sv */
// Toggle handshake that carries the status byte into the link clock domain.
// Assumes the destination clock may stop; a pending word waits for its edges.
`timescale 1ns/10ps
module sfw_word_xfer
  import sfw_pkg::*;
(
  input  wire logic           src_clk,
  input  wire logic           src_resetn,
  input  sfw_pkg::sfw_status_type src_word,
  input  wire logic           dst_clk,
  input  wire logic           dst_resetn,
  output sfw_pkg::sfw_status_type dst_word
);

  logic           req_q;
  logic           ack_q;
  logic           ack_s;
  logic           req_s;
  sfw_status_type hold_q;
  sfw_status_type word_q;

  // The held word only changes once the previous one was taken.
  always_ff @(posedge src_clk or negedge src_resetn) begin
    if (!src_resetn) begin
      req_q  <= 1'b0;
      hold_q <= '0;
    end else if (ack_s == req_q && src_word != hold_q) begin
      req_q  <= ~req_q;
      hold_q <= src_word;
    end
  end

  sfw_sync #(.W(1)) u_ack (
    .clk    (src_clk),
    .resetn (src_resetn),
    .d      (ack_q),
    .q      (ack_s)
  );

  sfw_sync #(.W(1)) u_req (
    .clk    (dst_clk),
    .resetn (dst_resetn),
    .d      (req_q),
    .q      (req_s)
  );

  // Stable hold word is sampled when the request toggle arrives.
  always_ff @(posedge dst_clk or negedge dst_resetn) begin
    if (!dst_resetn) begin
      ack_q  <= 1'b0;
      word_q <= '0;
    end else if (req_s != ack_q) begin
      ack_q  <= req_s;
      word_q <= hold_q;
    end
  end

  assign dst_word = word_q;

endmodule

/* File: verif/sfw_spi_master.sv */
// Behavioural SPI master that stands on the far side of the flash command block.
// Assumes mode 0; the serial clock runs only inside frames, 12 ns period.
`timescale 1ns/10ps
module sfw_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Idle levels before the first frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // One frame of n bits from tx[63] down; miso is caught at each rising edge.
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx   = '0;
    cs_n = 1'b0; // The model has no power-down state to identify in
    for (int i = 0; i < n; i++) begin
      mosi = tx[63-i];
      #6 sclk = 1'b1;
      rx = {rx[62:0], miso};
      #6 sclk = 1'b0;
    end
    // Release on the edge count chosen by the caller; the gap exceeds four clk periods.
    #6 cs_n = 1'b1;
    mosi = ~mosi;
    #30;
  endtask
endmodule

/* File: verif/spi_flash_wel_id_status_ctrl_test.sv */
// Self-checking bench for the serial flash command block.
// Assumes the SPI master model in this folder and the shared package.
`timescale 1ns/10ps
module spi_flash_wel_id_status_ctrl_test;
  import sfw_pkg::*;
  localparam int T_NS     = 1000;
  localparam int BUSY_CYC = T_NS * 200 / 1000;
  logic             clk, resetn, wp_n, sclk, cs_n, mosi, miso, miso_oe, pat, oe_seen;
  wire logic        miso_wire;
  sfw_status_type   status;
  sfw_array_op_type array_op;
  sfw_array_op_type exp_ops[$];
  int               mismatches, n_tests, busy_run;
  logic [63:0]      rx;
  logic [31:0]      r;

  // An undriven data line shows a toggling pattern, never a stale level.
  assign miso_wire = (miso_oe === 1'b1) ? miso : pat;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) pat <= ~pat;
  always @(posedge sclk) if (miso_oe === 1'b1) oe_seen <= 1'b1;

  // Busy is counted at every rising clk edge, so cycles that start during a frame gap are not lost.
  always @(posedge clk) if (status.busy === 1'b1) busy_run++;

  sfw_spi_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_wire));

  sfw_flash_ctrl #(.T_WSTATUS_NS(T_NS), .T_PROGRAM_NS(T_NS), .T_SECTOR_NS(T_NS),
                   .T_BULK_NS(T_NS)) dut (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
    .miso(miso), .miso_oe(miso_oe), .status(status), .array_op(array_op));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      mismatches++;
    end
  endtask

  task automatic check_op(input sfw_array_op_type e, input sfw_array_op_type g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH array_op expected %h seen %h", e, g);
      mismatches++;
    end
  endtask

  function automatic sfw_status_type st(input logic lk, input logic [2:0] p, input logic l,
                                        input logic b);
    return '{lock: lk, rsvd: 2'b00, prot: p, latch: l, busy: b};
  endfunction

  // Each start pulse takes the oldest note; an unexpected pulse fails at once.
  always @(posedge clk) begin
    if (array_op.valid === 1'b1) begin
      if (exp_ops.size() == 0) check_op('0, array_op);
      else check_op(exp_ops.pop_front(), array_op);
    end
  end

  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // Latch, send one write-type frame, then time the busy window and check the status.
  task automatic write_cmd(input int n, input logic [63:0] tx, input logic ok,
                           input sfw_kind_type k, input logic [2:0] p, input logic lk,
                           input logic probe);
    int cnt;
    cnt = 0;
    m.frame(8, {OP_SET_LATCH, 56'h0}, rx);
    if (ok) exp_ops.push_back('{valid: 1'b1, kind: k, addr_hi: tx[55:48]});
    busy_run = 0;
    m.frame(n, tx, rx);
    if (probe) begin
      m.frame(32, {OP_STATUS, 56'h0}, rx);
      check_val("status during cycle", st(lk, p, 1'b1, 1'b1), rx[7:0]);
      oe_seen = 1'b0;
      m.frame(16, {OP_IDENT, 56'h0}, rx);
      check_val("ident while busy", 1'b0, oe_seen);
    end
    // Poll busy as a master would; a cycle that never ends fails the run.
    while (cnt < 400 && (status.busy !== 1'b0 || cnt < 20)) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 400) begin
      mismatches++;
      complete_run();
    end
    check_val("busy cycles", ok ? BUSY_CYC : 0, busy_run);
    check_val("status after", st(lk, p, !ok, 1'b0), status);
  endtask

  initial begin
    resetn = 1'b0;
    wp_n   = 1'b1;
    pat    = 1'b0;
    oe_seen = 1'b0;
    mismatches = 0;
    n_tests = 0;
    r = $urandom(60458);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle();
    check_val("status at reset", 8'h00, status);
    m.frame(8, {OP_SET_LATCH, 56'h0}, rx);
    settle();
    check_val("latch set", st(1'b0, 3'h0, 1'b1, 1'b0), status);
    m.frame(24, {OP_STATUS, 56'h0}, rx);
    check_val("status repeated", 16'h0202, rx[15:0]);
    m.frame(8, {OP_CLR_LATCH, 56'h0}, rx);
    m.frame(7, {OP_SET_LATCH, 56'h0}, rx);
    m.frame(9, {OP_SET_LATCH, 56'h0}, rx);
    settle();
    check_val("latch after partial", 8'h00, status);
    m.frame(64, {OP_IDENT, 56'h0}, rx);
    check_val("ident", {ID_MAKER, ID_TYPE, ID_SIZE, ID_LENGTH, 24'h00_0000},
              rx[55:0]);
    m.frame(12, {OP_IDENT, 56'h0}, rx);
    m.frame(16, {OP_STATUS, 56'h0}, rx);
    check_val("status after abort", 8'h00, rx[7:0]);
    m.frame(16, {OP_WSTATUS, 8'h9C, 48'h0}, rx);
    settle();
    check_val("wstatus no latch", 8'h00, status);
    r = $urandom();
    write_cmd(16, {OP_WSTATUS, 1'b1, r[1:0], 3'h7, r[3:2], 48'h0}, 1'b1, KIND_WSTATUS,
              3'h7, 1'b1, 1'b1);
    write_cmd(8, {OP_BULK, 56'h0}, 1'b0, KIND_BULK, 3'h7, 1'b1, 1'b0);
    write_cmd(40, {OP_PROGRAM, 8'h00, r[23:0], 24'h0}, 1'b0, KIND_PROGRAM, 3'h7, 1'b1,
              1'b0);
    @(posedge clk) wp_n <= 1'b0;
    settle();
    write_cmd(16, {OP_WSTATUS, 56'h0}, 1'b0, KIND_WSTATUS, 3'h7, 1'b1, 1'b0);
    @(posedge clk) wp_n <= 1'b1;
    settle();
    write_cmd(16, {OP_WSTATUS, 8'h04, 48'h0}, 1'b1, KIND_WSTATUS, 3'h1, 1'b0,
              1'b0);
    write_cmd(40, {OP_PROGRAM, 8'h7F, r[31:8], 24'h0}, 1'b0, KIND_PROGRAM, 3'h1, 1'b0,
              1'b0);
    r = $urandom();
    write_cmd(40, {OP_PROGRAM, 2'b00, r[5:0], r[31:8], 24'h0}, 1'b1, KIND_PROGRAM, 3'h1,
              1'b0, 1'b0);
    write_cmd(32, {OP_SECTOR, 8'h20, r[15:0], 32'h0}, 1'b1, KIND_SECTOR, 3'h1, 1'b0,
              1'b0);
    write_cmd(16, {OP_WSTATUS, 56'h0}, 1'b1, KIND_WSTATUS, 3'h0, 1'b0, 1'b0);
    write_cmd(8, {OP_BULK, 56'h0}, 1'b1, KIND_BULK, 3'h0, 1'b0, 1'b0);
    check_val("pending ops", 0, exp_ops.size());
    complete_run();
  end

  // Watchdog: a hang counts as a mismatch and goes to the report.
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule
